// ===== uart_modem_control.sv
// Notes on behaviour
// - bit 6 enables infrared, write protected
// - bit 5 enables automatic flow control
// - loopback without infrared: serial out high, looped inward
// - interrupts keep working during loopback
// - user output b pin is inverted bit 3
// - user output a pin is inverted bit 2
// - loopback holds all four modem outputs high
// - manual mode: request pin inverted bit 1
// - auto flow, fifos on: stop at receive threshold
// - alternate trigger: stop at two free slots
// - terminal ready pin is inverted bit 0
// - threshold codes: one, quarter, half, two-less
// - fifo enable change resets both fifos
`timescale 1ns/1ps
module uart_modem_control
#(
  parameter int FIFO_DEPTH = 16,
  parameter int LEVEL_W    = 5
)
(
  // clock and reset
  input  wire logic                                i_ref_clk,
  input  wire logic                                i_rst,
  // register port
  input  wire logic [uart_modem_pkg::ADDR_W-1:0]   i_addr,
  input  wire logic [uart_modem_pkg::DATA_W-1:0]   i_wr_data,
  input  wire logic                                i_wr_en,
  input  wire logic                                i_rd_en,
  output logic      [uart_modem_pkg::DATA_W-1:0]   o_rd_data,
  // uart core side
  input  wire logic                                i_tx_serial,
  output logic                                     o_rx_serial,
  input  wire logic [LEVEL_W-1:0]                  i_rx_level,
  output logic                                     o_clear_to_send_st_n,
  output logic                                     o_data_set_ready_st_n,
  output logic                                     o_ring_indicator_st_n,
  output logic                                     o_carrier_detect_st_n,
  output logic                                     o_infrared_mode_enable,
  output logic                                     o_auto_flow_enable,
  output logic                                     o_fifo_on,
  output logic                                     o_tx_fifo_rst,
  output logic                                     o_rx_fifo_rst,
  // serial pins
  output logic                                     o_tx_pin,
  input  wire logic                                i_rx_pin,
  // modem pins
  input  wire logic                                i_clear_to_send_n,
  input  wire logic                                i_data_set_ready_n,
  input  wire logic                                i_ring_indicator_in_n,
  input  wire logic                                i_carrier_detect_n,
  output logic                                     o_rts_n,
  output logic                                     o_dtr_n,
  output logic                                     o_user_output_a_pin_n,
  output logic                                     o_user_output_b_pin_n,
  // static configuration pin
  input  wire logic                                i_almost_full_sel
);

  // ==========================================================
  // pin synchronisers
  localparam int          SYNC_W   = 6;
  localparam logic [5:0]  SYNC_RST = 6'h1f;

  logic [SYNC_W-1:0] meta_r;
  logic [SYNC_W-1:0] sync_r;
  logic              rx_pin_s;
  logic              cts_s;
  logic              dsr_s;
  logic              ring_s;
  logic              dcd_s;
  logic              sel_s;

  // idle levels: line high, modem inputs inactive, select low
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      meta_r <= SYNC_RST;
      sync_r <= SYNC_RST;
    end
    else
    begin
      meta_r <= {i_almost_full_sel, i_carrier_detect_n,
                 i_ring_indicator_in_n, i_data_set_ready_n,
                 i_clear_to_send_n, i_rx_pin};
      sync_r <= meta_r;
    end
  end

  assign rx_pin_s = sync_r[0];
  assign cts_s    = sync_r[1];
  assign dsr_s    = sync_r[2];
  assign ring_s   = sync_r[3];
  assign dcd_s    = sync_r[4];
  assign sel_s    = sync_r[5];

  // ==========================================================
  // bus decode
  logic wr_mc;
  logic wr_fc;
  logic wr_key;

  assign wr_mc  = i_wr_en && (i_addr == uart_modem_pkg::MODEM_CONTROL_OFF);
  assign wr_fc  = i_wr_en && (i_addr == uart_modem_pkg::FIFO_CONTROL_OFF);
  assign wr_key = i_wr_en && (i_addr == uart_modem_pkg::WP_KEY_OFF);

  // ==========================================================
  // modem_control register
  logic [uart_modem_pkg::MC_W-1:0] mc_r;
  logic                            unlock_r;

  // key arms exactly one following write; any other write disarms
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
      unlock_r <= 1'b0;
    else if (i_wr_en)
      unlock_r <= wr_key && (i_wr_data == uart_modem_pkg::WP_KEY_VALUE);
  end

  // infrared bit only moves while unlocked
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
      mc_r <= uart_modem_pkg::MODEM_CONTROL_RST;
    else if (wr_mc)
    begin
      mc_r[uart_modem_pkg::AUTO_BIT:0] <=
        i_wr_data[uart_modem_pkg::AUTO_BIT:0];
      if (unlock_r)
        mc_r[uart_modem_pkg::IR_BIT] <=
          i_wr_data[uart_modem_pkg::IR_BIT];
    end
  end

  logic loop;
  logic auto_fc;
  logic serial_loop;

  assign loop        = mc_r[uart_modem_pkg::LOOP_BIT];
  assign auto_fc     = mc_r[uart_modem_pkg::AUTO_BIT];
  // infrared path owns the line, so no serial loop there
  assign serial_loop = loop && !mc_r[uart_modem_pkg::IR_BIT];

  // ==========================================================
  // fifo_control register
  logic                    fifo_on_r;
  uart_modem_pkg::rx_trig_t rx_trig_r;
  logic                    fifo_flip;

  assign fifo_flip = wr_fc &&
    (i_wr_data[uart_modem_pkg::FIFO_ON_BIT] != fifo_on_r);

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      fifo_on_r <= 1'b0;
      rx_trig_r <= uart_modem_pkg::TRIG_ONE;
    end
    else if (wr_fc)
    begin
      fifo_on_r <= i_wr_data[uart_modem_pkg::FIFO_ON_BIT];
      rx_trig_r <= uart_modem_pkg::rx_trig_t'(
        i_wr_data[uart_modem_pkg::RX_TRIG_LSB +: 2]);
    end
  end

  // reset strobes are one cycle; a flip resets both sides
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      o_rx_fifo_rst <= 1'b0;
      o_tx_fifo_rst <= 1'b0;
    end
    else
    begin
      o_rx_fifo_rst <= fifo_flip || (wr_fc &&
        i_wr_data[uart_modem_pkg::RX_RST_BIT]);
      o_tx_fifo_rst <= fifo_flip || (wr_fc &&
        i_wr_data[uart_modem_pkg::TX_RST_BIT]);
    end
  end

  // ==========================================================
  // flow gating
  logic alt_sel_r;

  // follows the synchronised pin every cycle, threshold gating by default
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
      alt_sel_r <= 1'b0;
    else
      alt_sel_r <= sel_s;
  end

  // fill level at which the sender is told to pause
  function automatic logic [LEVEL_W:0] trig_level
  (
    input uart_modem_pkg::rx_trig_t code
  );
    logic [LEVEL_W:0] lvl;
    lvl = '0;
    unique case (code)
      uart_modem_pkg::TRIG_ONE:      lvl = (LEVEL_W+1)'(1);
      uart_modem_pkg::TRIG_QUARTER:  lvl = (LEVEL_W+1)'(FIFO_DEPTH/4);
      uart_modem_pkg::TRIG_HALF:     lvl = (LEVEL_W+1)'(FIFO_DEPTH/2);
      uart_modem_pkg::TRIG_TWO_LESS: lvl = (LEVEL_W+1)'(FIFO_DEPTH -
        uart_modem_pkg::ALMOST_FULL_SLOTS);
    endcase
    return lvl;
  endfunction : trig_level

  logic [LEVEL_W:0] level_x;
  logic [LEVEL_W:0] thresh;
  logic [LEVEL_W:0] almost_full;
  logic             rx_stop;
  logic             rts_ctl;

  assign level_x     = {1'b0, i_rx_level};
  assign thresh      = trig_level(rx_trig_r);
  assign almost_full = (LEVEL_W+1)'(FIFO_DEPTH -
                       uart_modem_pkg::ALMOST_FULL_SLOTS);
  assign rx_stop     = alt_sel_r ? (level_x >= almost_full)
                                 : (level_x >= thresh);
  // gating applies only with fifos on; otherwise bit 1 alone
  assign rts_ctl     = mc_r[uart_modem_pkg::RTS_BIT] &&
                       !(auto_fc && fifo_on_r && rx_stop);

  // ==========================================================
  // modem output pins, idle high in loopback
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      o_rts_n               <= 1'b1;
      o_dtr_n               <= 1'b1;
      o_user_output_a_pin_n <= 1'b1;
      o_user_output_b_pin_n <= 1'b1;
    end
    else
    begin
      o_rts_n               <= loop || !rts_ctl;
      o_dtr_n               <= loop ||
        !mc_r[uart_modem_pkg::DTR_BIT];
      o_user_output_a_pin_n <= loop ||
        !mc_r[uart_modem_pkg::OUT_A_BIT];
      o_user_output_b_pin_n <= loop ||
        !mc_r[uart_modem_pkg::OUT_B_BIT];
    end
  end

  // ==========================================================
  // modem status toward the core
  // in loopback the control bits stand in for the pins, so the
  // core's change detection and interrupts run unchanged
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      o_clear_to_send_st_n  <= 1'b1;
      o_data_set_ready_st_n <= 1'b1;
      o_ring_indicator_st_n <= 1'b1;
      o_carrier_detect_st_n <= 1'b1;
    end
    else if (loop)
    begin
      o_clear_to_send_st_n  <= !mc_r[uart_modem_pkg::RTS_BIT];
      o_data_set_ready_st_n <= !mc_r[uart_modem_pkg::DTR_BIT];
      o_ring_indicator_st_n <= !mc_r[uart_modem_pkg::OUT_A_BIT];
      o_carrier_detect_st_n <= !mc_r[uart_modem_pkg::OUT_B_BIT];
    end
    else
    begin
      o_clear_to_send_st_n  <= cts_s;
      o_data_set_ready_st_n <= dsr_s;
      o_ring_indicator_st_n <= ring_s;
      o_carrier_detect_st_n <= dcd_s;
    end
  end

  // ==========================================================
  // serial path and mode outputs
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      o_tx_pin    <= 1'b1;
      o_rx_serial <= 1'b1;
    end
    else
    begin
      o_tx_pin    <= serial_loop || i_tx_serial;
      o_rx_serial <= serial_loop ? i_tx_serial : rx_pin_s;
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      o_infrared_mode_enable <= 1'b0;
      o_auto_flow_enable     <= 1'b0;
      o_fifo_on              <= 1'b0;
    end
    else
    begin
      o_infrared_mode_enable <= mc_r[uart_modem_pkg::IR_BIT];
      o_auto_flow_enable     <= auto_fc;
      o_fifo_on              <= fifo_on_r;
    end
  end

  // ==========================================================
  // read port; unmapped offsets read zero
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst || !i_rd_en)
      o_rd_data <= '0;
    else
    begin
      unique case (i_addr)
        uart_modem_pkg::MODEM_CONTROL_OFF:
          o_rd_data <= {25'h0, mc_r};
        uart_modem_pkg::FIFO_CONTROL_OFF:
          o_rd_data <= {24'h0, rx_trig_r, 5'h00, fifo_on_r};
        uart_modem_pkg::MODEM_STATUS_OFF:
          o_rd_data <= {27'h0, o_rts_n, o_carrier_detect_st_n,
                        o_ring_indicator_st_n, o_data_set_ready_st_n,
                        o_clear_to_send_st_n};
        default:
          o_rd_data <= '0;
      endcase
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);

  sequence s_locked_write;
    wr_mc && !unlock_r;
  endsequence

  sequence s_serial_loop;
    serial_loop;
  endsequence

  sequence s_auto_gate;
    !loop && auto_fc && fifo_on_r;
  endsequence

  a_ir_protected: assert property (
    s_locked_write |=> $stable(mc_r[uart_modem_pkg::IR_BIT])
  ) else $error("infrared bit changed without unlock");

  a_auto_flow_bit: assert property (
    wr_mc ##1 1'b1 |=> o_auto_flow_enable ==
      $past(i_wr_data[uart_modem_pkg::AUTO_BIT], 2)
  ) else $error("auto flow output not following write");

  a_loop_tx_high: assert property (
    s_serial_loop |=> o_tx_pin && o_rx_serial == $past(i_tx_serial)
  ) else $error("serial loop not routed");

  a_loop_status: assert property (
    loop |=> o_clear_to_send_st_n ==
      !$past(mc_r[uart_modem_pkg::RTS_BIT]) &&
      o_carrier_detect_st_n == !$past(mc_r[uart_modem_pkg::OUT_B_BIT])
  ) else $error("modem status not looped back");

  a_user_b_pin: assert property (
    !loop |=> o_user_output_b_pin_n ==
      !$past(mc_r[uart_modem_pkg::OUT_B_BIT])
  ) else $error("user output b pin wrong");

  a_user_a_pin: assert property (
    !loop |=> o_user_output_a_pin_n ==
      !$past(mc_r[uart_modem_pkg::OUT_A_BIT])
  ) else $error("user output a pin wrong");

  a_loop_pins_idle: assert property (
    loop |=> o_rts_n && o_dtr_n &&
      o_user_output_a_pin_n && o_user_output_b_pin_n
  ) else $error("modem pin active in loopback");

  a_rts_manual: assert property (
    !loop && !auto_fc |=> o_rts_n ==
      !$past(mc_r[uart_modem_pkg::RTS_BIT])
  ) else $error("request pin not inverted bit");

  a_rts_threshold: assert property (
    s_auto_gate ##0 !alt_sel_r && level_x >= thresh |=> o_rts_n
  ) else $error("request pin active above threshold");

  a_rts_almost: assert property (
    s_auto_gate ##0 alt_sel_r &&
      level_x >= (LEVEL_W+1)'(FIFO_DEPTH - 2) |=> o_rts_n
  ) else $error("request pin active near full");

  a_dtr_pin: assert property (
    !loop |=> o_dtr_n == !$past(mc_r[uart_modem_pkg::DTR_BIT])
  ) else $error("terminal ready pin wrong");

  a_trig_codes: assert property (
    rx_trig_r == uart_modem_pkg::TRIG_TWO_LESS |->
      thresh == (LEVEL_W+1)'(FIFO_DEPTH - 2)
  ) else $error("threshold code decoded wrongly");

  a_fifo_flip_rst: assert property (
    fifo_flip |=> o_rx_fifo_rst && o_tx_fifo_rst ##1
      o_fifo_on != $past(o_fifo_on)
  ) else $error("fifo enable change without reset");

  a_alt_default: assert property (
    $past(i_rst) |-> !alt_sel_r
  ) else $error("gating select not default after reset");

endmodule : uart_modem_control

// ===== uart_modem_pkg.sv
package uart_modem_pkg;

  // ==========================================================
  // bus geometry
  localparam int          ADDR_W            = 8;
  localparam int          DATA_W            = 32;

  // ==========================================================
  // register offsets
  localparam logic [7:0]  FIFO_CONTROL_OFF  = 8'h08;
  localparam logic [7:0]  MODEM_CONTROL_OFF = 8'h10;
  localparam logic [7:0]  MODEM_STATUS_OFF  = 8'h18;
  localparam logic [7:0]  WP_KEY_OFF        = 8'h40;

  // ==========================================================
  // reset values and unlock key (key value is arbitrary)
  localparam logic [6:0]  MODEM_CONTROL_RST = 7'h00;
  localparam logic [31:0] WP_KEY_VALUE      = 32'h0000_a55a;

  // ==========================================================
  // modem_control fields
  localparam int          MC_W              = 7;
  localparam int          DTR_BIT           = 0;
  localparam int          RTS_BIT           = 1;
  localparam int          OUT_A_BIT         = 2;
  localparam int          OUT_B_BIT         = 3;
  localparam int          LOOP_BIT          = 4;
  localparam int          AUTO_BIT          = 5;
  localparam int          IR_BIT            = 6;

  // ==========================================================
  // fifo_control fields
  localparam int          FIFO_ON_BIT       = 0;
  localparam int          RX_RST_BIT        = 1;
  localparam int          TX_RST_BIT        = 2;
  localparam int          RX_TRIG_LSB       = 6;
  localparam int          ALMOST_FULL_SLOTS = 2;

  // ==========================================================
  // modem status read fields
  localparam int          ST_CTS_BIT        = 0;
  localparam int          ST_DSR_BIT        = 1;
  localparam int          ST_RING_BIT       = 2;
  localparam int          ST_DCD_BIT        = 3;
  localparam int          ST_RTS_PIN_BIT    = 4;

  // receive threshold codes
  typedef enum logic [1:0]
  {
    TRIG_ONE      = 2'b00,
    TRIG_QUARTER  = 2'b01,
    TRIG_HALF     = 2'b10,
    TRIG_TWO_LESS = 2'b11
  } rx_trig_t;

endpackage : uart_modem_pkg

// ===== modem_partner.sv
`timescale 1ns/1ps
// ==========================================================
// far-side modem: answers the uart's handshake lines
module modem_partner
(
  // clock
  input  wire logic       i_ref_clk,
  // handshake from the uart; slow select and line state from the test
  input  wire logic       i_rts_n,
  input  wire logic       i_dtr_n,
  input  wire logic       i_slow,
  input  wire logic [1:0] i_line_st_n,
  // handshake to the uart
  output logic            o_cts_n,
  output logic            o_dsr_n,
  output logic            o_ring_n,
  output logic            o_dcd_n
);
  logic [3:0] rts_dly_r;

  // clear-to-send echoes request one cycle late, or five cycles late when slow
  always_ff @(posedge i_ref_clk)
  begin
    rts_dly_r <= {rts_dly_r[2:0], i_rts_n};
    o_cts_n   <= i_slow ? rts_dly_r[3] : i_rts_n;
    o_dsr_n   <= i_dtr_n;
    o_ring_n  <= i_line_st_n[0];
    o_dcd_n   <= i_line_st_n[1];
  end
endmodule : modem_partner

// ===== tb_top.sv
`timescale 1ns/1ps
module tb_top;
  // ==========================================================
  // stimulus and observed signals
  localparam int DEPTH = 16;
  localparam int LW    = 5;
  logic          clk     = 1'b0;
  logic          rst     = 1'b1;
  logic [7:0]    addr    = 8'h00;
  logic [31:0]   wdata   = 32'h0;
  logic          wr      = 1'b0;
  logic          rd      = 1'b0;
  logic          txs     = 1'b1;
  logic          rx_pin  = 1'b1;
  logic          af_sel  = 1'b0;
  logic          slow    = 1'b0;
  logic [1:0]    line_n  = 2'h3;
  logic [LW-1:0] lvl     = 5'h00;
  logic [31:0]   seed    = 32'h0000_1300;
  logic [31:0]   rdata;
  logic          rxs, tx_pin, ir_en, af_en, f_on, ttx, trx;
  logic          cts_st_n, dsr_st_n, ring_st_n, dcd_st_n;
  logic          cts_n, dsr_n, ring_n, dcd_n;
  logic          rts_n, dtr_n, oa_n, ob_n;
  int            bad_count = 0;
  int            n_checks  = 0;
  int            tx_pulses = 0;
  int            rx_pulses = 0;

  always #5 clk = ~clk;

  uart_modem_control #(.FIFO_DEPTH(DEPTH), .LEVEL_W(LW)) uut
  (
    .i_ref_clk(clk), .i_rst(rst), .i_addr(addr), .i_wr_data(wdata),
    .i_wr_en(wr), .i_rd_en(rd), .o_rd_data(rdata),
    .i_tx_serial(txs), .o_rx_serial(rxs), .i_rx_level(lvl),
    .o_clear_to_send_st_n(cts_st_n), .o_data_set_ready_st_n(dsr_st_n),
    .o_ring_indicator_st_n(ring_st_n), .o_carrier_detect_st_n(dcd_st_n),
    .o_infrared_mode_enable(ir_en), .o_auto_flow_enable(af_en),
    .o_fifo_on(f_on), .o_tx_fifo_rst(ttx), .o_rx_fifo_rst(trx),
    .o_tx_pin(tx_pin), .i_rx_pin(rx_pin),
    .i_clear_to_send_n(cts_n), .i_data_set_ready_n(dsr_n),
    .i_ring_indicator_in_n(ring_n), .i_carrier_detect_n(dcd_n),
    .o_rts_n(rts_n), .o_dtr_n(dtr_n), .o_user_output_a_pin_n(oa_n),
    .o_user_output_b_pin_n(ob_n), .i_almost_full_sel(af_sel)
  );

  modem_partner modem
  (
    .i_ref_clk(clk), .i_rts_n(rts_n), .i_dtr_n(dtr_n), .i_slow(slow),
    .i_line_st_n(line_n), .o_cts_n(cts_n), .o_dsr_n(dsr_n),
    .o_ring_n(ring_n), .o_dcd_n(dcd_n)
  );

  // count fifo reset pulses mid-cycle, away from the launching edge
  always @(negedge clk)
  begin
    if (ttx === 1'b1) tx_pulses++;
    if (trx === 1'b1) rx_pulses++;
  end

  // ==========================================================
  // helpers
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  function automatic int thr_of(logic [1:0] code, logic alt);
    if (alt) return DEPTH - 2;
    case (code)
      2'h0:    return 1;
      2'h1:    return DEPTH / 4;
      2'h2:    return DEPTH / 2;
      default: return DEPTH - 2;
    endcase
  endfunction : thr_of

  // {user b, user a, terminal ready, request} as seen on the pins
  function automatic logic [3:0] exp_pins(logic [6:0] mc, logic gate);
    if (mc[4]) return 4'hf;
    return {~mc[3], ~mc[2], ~mc[0], ~mc[1] | gate};
  endfunction : exp_pins

  task automatic chk(input string nm, input logic [31:0] exp, got);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg

  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : summarize

  // ==========================================================
  // watchdog: whole sequence needs well under 3000 cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    summarize();
  end

  // ==========================================================
  // main sequence
  initial
  begin
    logic [31:0] d;
    logic [31:0] r;
    logic [6:0]  mc;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    settle(3);
    rd_reg(8'h10, r);
    chk("control reset", 32'h0, r);
    chk("pins reset", 32'hf, 32'({ob_n, oa_n, dtr_n, rts_n}));
    // normal mode; fifo off, so a full level must not gate
    repeat (12)
    begin
      d  = xs();
      mc = {1'b0, d[5], 1'b0, d[3:0]};
      @(posedge clk);
      txs    <= d[8];
      rx_pin <= d[9];
      line_n <= d[11:10];
      slow   <= d[12];
      lvl    <= d[20:16];
      wr_reg(8'h10, 32'(mc));
      settle(12);
      chk("pins", 32'(exp_pins(mc, 1'b0)),
          32'({ob_n, oa_n, dtr_n, rts_n}));
      chk("tx pin", 32'(d[8]), 32'(tx_pin));
      chk("rx serial", 32'(d[9]), 32'(rxs));
      chk("status", 32'({d[11:10], ~mc[0], ~mc[1]}),
          32'({dcd_st_n, ring_st_n, dsr_st_n, cts_st_n}));
      chk("auto copy", 32'(mc[5]), 32'(af_en));
      rd_reg(8'h10, r);
      chk("readback", 32'(mc), r);
    end
    // infrared bit refuses a write without the key
    wr_reg(8'h10, 32'h40);
    rd_reg(8'h10, r);
    chk("ir locked", 32'h0, r);
    // infrared with loopback: line not held high, no serial loop
    wr_reg(uart_modem_pkg::WP_KEY_OFF, uart_modem_pkg::WP_KEY_VALUE);
    txs <= 1'b0;
    wr_reg(8'h10, 32'h50);
    rd_reg(8'h10, r);
    chk("ir unlocked", 32'h50, r);
    chk("ir enable", 32'h1, 32'(ir_en));
    chk("ir loop tx pin", 32'h0, 32'(tx_pin));
    chk("ir loop pins", 32'hf, 32'({ob_n, oa_n, dtr_n, rts_n}));
    wr_reg(uart_modem_pkg::WP_KEY_OFF, uart_modem_pkg::WP_KEY_VALUE);
    wr_reg(8'h10, 32'h0);
    // loopback: pins idle, outputs fed back, external inputs ignored
    repeat (8)
    begin
      d  = xs();
      mc = {3'b001, d[3:0]};
      @(posedge clk);
      txs    <= d[8];
      rx_pin <= ~d[8];
      line_n <= d[11:10];
      wr_reg(8'h10, 32'(mc));
      settle(12);
      chk("loop pins", 32'(exp_pins(mc, 1'b0)),
          32'({ob_n, oa_n, dtr_n, rts_n}));
      chk("loop tx pin", 32'h1, 32'(tx_pin));
      chk("loop rx", 32'(d[8]), 32'(rxs));
      chk("loop status", 32'({~mc[3], ~mc[2], ~mc[0], ~mc[1]}),
          32'({dcd_st_n, ring_st_n, dsr_st_n, cts_st_n}));
      rd_reg(8'h18, r);
      chk("status read",
          32'({1'b1, ~mc[3], ~mc[2], ~mc[0], ~mc[1]}), r);
    end
    // auto flow: every threshold code, both gating modes, both sides
    wr_reg(8'h10, 32'h22);
    for (int c = 0; c < 4; c++)
      for (int a = 0; a < 2; a++)
      begin
        @(posedge clk);
        af_sel <= a[0];
        wr_reg(8'h08, {24'h0, c[1:0], 6'h01});
        for (int k = -1; k < 1; k++)
        begin
          @(posedge clk);
          lvl <= LW'(thr_of(c[1:0], a[0]) + k);
          settle(5);
          chk("gated rts", 32'(exp_pins(7'h22, k == 0)),
              32'({ob_n, oa_n, dtr_n, rts_n}));
        end
        rd_reg(8'h08, r);
        chk("fifo control", {24'h0, c[1:0], 6'h01}, r);
        chk("fifo on set", 32'h1, 32'(f_on));
      end
    @(posedge clk);
    af_sel <= 1'b0;
    // turning fifos off resets both once; a rewrite does nothing
    tx_pulses = 0;
    rx_pulses = 0;
    wr_reg(8'h08, 32'h0);
    settle(4);
    chk("fifo rst pulses", 32'h0001_0001,
        {16'(tx_pulses), 16'(rx_pulses)});
    chk("fifo on", 32'h0, 32'(f_on));
    tx_pulses = 0;
    rx_pulses = 0;
    wr_reg(8'h08, 32'h0);
    settle(4);
    chk("no rst pulse", 32'h0, {16'(tx_pulses), 16'(rx_pulses)});
    // receive reset bit alone strobes only the receive side
    tx_pulses = 0;
    rx_pulses = 0;
    wr_reg(8'h08, 32'h02);
    settle(4);
    chk("rx rst only", 32'h1, {16'(tx_pulses), 16'(rx_pulses)});
    // fifos off: a full level must not gate the request
    @(posedge clk);
    lvl <= 5'h0f;
    settle(5);
    chk("ungated rts", 32'(exp_pins(7'h22, 1'b0)),
        32'({ob_n, oa_n, dtr_n, rts_n}));
    // unmapped place: write ignored, read zero, data last one cycle
    wr_reg(8'h24, 32'hffff_ffff);
    rd_reg(8'h10, r);
    chk("after stray write", 32'h22, r);
    rd_reg(8'h24, r);
    chk("unmapped read", 32'h0, r);
    rd_reg(8'h10, r);
    settle(1);
    chk("read data cleared", 32'h0, rdata);
    summarize();
  end
endmodule : tb_top
